// ### core/frep_seq.sv
/*
 * Flash row erase/program sequencer with APB register access.
 * Assumes the core stalls on stall_o and that the flash array takes
 * one erase or program request per cycle and needs no handshake back.
 */
`timescale 1ns/10ps
`include "frep_cfg.svh"
module frep_seq
#(
	parameter int ERASE_CYC = `FREP_ERASE_CYC,
	parameter int PROG_CYC = `FREP_PROG_CYC
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Core stall
	output logic stall_o,
	// Flash array
	output logic fl_erase_o,
	output logic fl_prog_o,
	output logic [23:0] fl_row_addr_o,
	output logic [767:0] fl_row_data_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		frep_pkg::frep_state_e st;
		frep_pkg::frep_key_e key;
		logic start;
		logic enable;
		logic [7:0] cmd;
		logic [7:0] addr_hi;
		logic [15:0] addr_lo;
		logic [7:0] page;
		logic [15:0] tbl_ofs;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic stall;
		logic erase;
		logic prog;
		logic [23:0] row_addr;
	} frep_seq_s;

	frep_seq_s s_ff;
	frep_seq_s nxt_s;

	frep_latch_if lat ();

	logic tmr_start;
	logic [23:0] tmr_len;
	logic tmr_done;

	// Register index decode, used for both read and write
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	// ----------------------------------------------------------------
	// Sequencer and register file
	// ----------------------------------------------------------------
	logic wr_acc;
	logic rd_acc;
	logic any_acc;
	logic cmd_ok;
	logic mapped;

	assign any_acc = psel_i && penable_i && !s_ff.ready;
	assign wr_acc = any_acc && pwrite_i;
	assign rd_acc = any_acc && !pwrite_i;
	assign cmd_ok = (s_ff.cmd == `FREP_CMD_ERASE_ROW) ||
		(s_ff.cmd == `FREP_CMD_PROG_ROW);
	assign mapped = paddr_i[11:5] == 7'h00 && paddr_i[1:0] == 2'b00;

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.ready = 1'b0;
		nxt_s.slverr = 1'b0;
		nxt_s.erase = 1'b0;
		nxt_s.prog = 1'b0;
		tmr_start = 1'b0;
		tmr_len = 24'h000000;
		lat.wr_lo = 1'b0;
		lat.wr_hi = 1'b0;
		lat.sel = s_ff.tbl_ofs[5:1];
		lat.wdata = pwdata_i[15:0];

		// One-wait-state APB answer for every access
		if (any_acc)
		begin
			nxt_s.ready = 1'b1;
			nxt_s.slverr = !mapped;
			nxt_s.rdata = 32'h00000000;
		end

		// Reads show the block's own state
		if (rd_acc)
		begin
			if (hit(paddr_i, `FREP_OFS_CONTROL))
			begin
				nxt_s.rdata = {16'h0000, s_ff.start, s_ff.enable, 6'h00, s_ff.cmd};
			end
			if (hit(paddr_i, `FREP_OFS_ADDR_LO))
			begin
				nxt_s.rdata = {16'h0000, s_ff.addr_lo};
			end
			if (hit(paddr_i, `FREP_OFS_ADDR_HI))
			begin
				nxt_s.rdata = {24'h000000, s_ff.addr_hi};
			end
			if (hit(paddr_i, `FREP_OFS_PAGE))
			begin
				nxt_s.rdata = {24'h000000, s_ff.page};
			end
			if (hit(paddr_i, `FREP_OFS_TBL_OFS))
			begin
				nxt_s.rdata = {16'h0000, s_ff.tbl_ofs};
			end
		end

		// Any write other than the first or second key breaks a half-open unlock
		if (wr_acc && s_ff.st == frep_pkg::FREP_IDLE)
		begin
			if (!hit(paddr_i, `FREP_OFS_KEY) && !hit(paddr_i, `FREP_OFS_CONTROL))
			begin
				nxt_s.key = frep_pkg::FREP_KEY_NONE;
			end
			if (hit(paddr_i, `FREP_OFS_KEY))
			begin
				if (pwdata_i[7:0] == `FREP_KEY_FIRST)
				begin
					nxt_s.key = frep_pkg::FREP_KEY_HALF;
				end
				else if (pwdata_i[7:0] == `FREP_KEY_SECOND &&
					s_ff.key == frep_pkg::FREP_KEY_HALF)
				begin
					nxt_s.key = frep_pkg::FREP_KEY_OPEN;
				end
				else
				begin
					nxt_s.key = frep_pkg::FREP_KEY_NONE;
				end
			end
			if (hit(paddr_i, `FREP_OFS_CONTROL))
			begin
				nxt_s.enable = pwdata_i[`FREP_CTL_ENABLE_BIT];
				nxt_s.cmd = pwdata_i[7:0];
				nxt_s.key = frep_pkg::FREP_KEY_NONE;
				// Start only from an open unlock, with enable and a known command
				if (pwdata_i[`FREP_CTL_START_BIT] && s_ff.key == frep_pkg::FREP_KEY_OPEN &&
					pwdata_i[`FREP_CTL_ENABLE_BIT] && s_ff.enable && cmd_ok)
				begin
					nxt_s.start = 1'b1;
					nxt_s.stall = 1'b1;
					nxt_s.st = frep_pkg::FREP_BUSY;
					tmr_start = 1'b1;
					if (s_ff.cmd == `FREP_CMD_ERASE_ROW)
					begin
						nxt_s.erase = 1'b1;
						tmr_len = 24'(ERASE_CYC);
					end
					else
					begin
						nxt_s.prog = 1'b1;
						tmr_len = 24'(PROG_CYC);
					end
					// Row boundary: lowest six bits dropped for both operations
					nxt_s.row_addr = {s_ff.addr_hi, s_ff.addr_lo[15:`FREP_ROW_LSB],
						6'h00};
				end
			end
			if (hit(paddr_i, `FREP_OFS_ADDR_LO))
			begin
				nxt_s.addr_lo = pwdata_i[15:0];
			end
			if (hit(paddr_i, `FREP_OFS_ADDR_HI))
			begin
				nxt_s.addr_hi = pwdata_i[7:0];
			end
			if (hit(paddr_i, `FREP_OFS_PAGE))
			begin
				nxt_s.page = pwdata_i[7:0];
			end
			if (hit(paddr_i, `FREP_OFS_TBL_OFS))
			begin
				nxt_s.tbl_ofs = pwdata_i[15:0];
			end
			// Table writes fill a latch and capture the full address
			if (hit(paddr_i, `FREP_OFS_TBL_LO) || hit(paddr_i, `FREP_OFS_TBL_HI))
			begin
				nxt_s.addr_hi = s_ff.page;
				nxt_s.addr_lo = s_ff.tbl_ofs;
				if (hit(paddr_i, `FREP_OFS_TBL_LO))
				begin
					lat.wr_lo = 1'b1;
				end
				else
				begin
					lat.wr_hi = 1'b1;
					// High byte optionally post-increments to the next word
					if (pwdata_i[31])
					begin
						nxt_s.tbl_ofs = s_ff.tbl_ofs + 16'h0002;
					end
				end
			end
		end

		// Cycle end frees the core and clears start and enable
		unique case (s_ff.st)
			frep_pkg::FREP_IDLE:
			begin
			end
			frep_pkg::FREP_BUSY:
			begin
				if (tmr_done)
				begin
					nxt_s.st = frep_pkg::FREP_DONE;
				end
			end
			frep_pkg::FREP_DONE:
			begin
				nxt_s.start = 1'b0;
				nxt_s.enable = 1'b0;
				nxt_s.stall = 1'b0;
				nxt_s.st = frep_pkg::FREP_IDLE;
			end
			default:
			begin
				nxt_s.st = frep_pkg::FREP_IDLE;
			end
		endcase
	end

	// Single state register
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			s_ff <= '0;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	frep_latch_bank #(.WORDS(`FREP_ROW_WORDS)) u_bank
	(
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.lat(lat.bank)
	);

	frep_flash_timer #(.CNT_W(24)) u_tmr
	(
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(tmr_start),
		.len_i(tmr_len),
		.done_o(tmr_done)
	);

	// Row data registered so the output comes from a flip-flop
	logic [767:0] row_ff;
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			row_ff <= '0;
		end
		else if (nxt_s.prog)
		begin
			row_ff <= lat.row;
		end
	end

	assign prdata_o = s_ff.rdata;
	assign pready_o = s_ff.ready;
	assign pslverr_o = s_ff.slverr;
	assign stall_o = s_ff.stall;
	assign fl_erase_o = s_ff.erase;
	assign fl_prog_o = s_ff.prog;
	assign fl_row_addr_o = s_ff.row_addr;
	assign fl_row_data_o = row_ff;

endmodule

// ### common/frep_cfg.svh
/*
 * Offsets, field positions, command and key values and timing counts for the
 * flash row erase/program sequencer.
 * Assumes inclusion by bare name from design files.
 */
`ifndef FREP_CFG_SVH
`define FREP_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB slave
// ----------------------------------------------------------------
`define FREP_OFS_CONTROL 12'h000
`define FREP_OFS_ADDR_LO 12'h004
`define FREP_OFS_ADDR_HI 12'h008
`define FREP_OFS_KEY 12'h00c
`define FREP_OFS_PAGE 12'h010
`define FREP_OFS_TBL_LO 12'h014
`define FREP_OFS_TBL_HI 12'h018
`define FREP_OFS_TBL_OFS 12'h01c

// ----------------------------------------------------------------
// Control register fields and values
// ----------------------------------------------------------------
`define FREP_CTL_START_BIT 15
`define FREP_CTL_ENABLE_BIT 14
`define FREP_CMD_ERASE_ROW 8'h41
`define FREP_CMD_PROG_ROW 8'h01
`define FREP_KEY_FIRST 8'h55
`define FREP_KEY_SECOND 8'haa

// ----------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------
`define FREP_ROW_WORDS 32
`define FREP_ROW_LSB 6
`define FREP_ADDR_LO_W 16
`define FREP_ADDR_HI_W 8
`define FREP_CLK_MHZ 200
`define FREP_ERASE_US 2000
`define FREP_PROG_US 2000
`define FREP_ERASE_CYC (`FREP_ERASE_US * `FREP_CLK_MHZ)
`define FREP_PROG_CYC (`FREP_PROG_US * `FREP_CLK_MHZ)

`endif

// ### common/frep_pkg.sv
/*
 * Types for the flash row erase/program sequencer.
 * Assumes the configuration header holds the numbers.
 */
package frep_pkg;

	// Sequencer states, Gray coded along idle-busy-done
	typedef enum logic [1:0]
	{
		FREP_IDLE = 2'b00,
		FREP_BUSY = 2'b01,
		FREP_DONE = 2'b11
	} frep_state_e;

	// Unlock tracker states
	typedef enum logic [1:0]
	{
		FREP_KEY_NONE = 2'b00,
		FREP_KEY_HALF = 2'b01,
		FREP_KEY_OPEN = 2'b11
	} frep_key_e;

	typedef logic [23:0] frep_addr_t;

endpackage

// ### common/frep_latch_if.sv
/*
 * Carrier between the sequencer and its write latch bank.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
interface frep_latch_if;
	logic wr_lo;
	logic wr_hi;
	logic [4:0] sel;
	logic [15:0] wdata;
	logic [767:0] row;

	// Sequencer writes, bank holds the row
	modport ctrl
	(
		output wr_lo,
		output wr_hi,
		output sel,
		output wdata,
		input row
	);
	modport bank
	(
		input wr_lo,
		input wr_hi,
		input sel,
		input wdata,
		output row
	);
endinterface

// ### core/frep_latch_bank.sv
/*
 * Bank of 32 write latches of 24 bits each (768 bits).
 * Assumes writes arrive from the sequencer as low word then high byte.
 */
`timescale 1ns/10ps
module frep_latch_bank
#(
	parameter int WORDS = 32
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Latch port
	frep_latch_if.bank lat
);

	typedef struct packed
	{
		logic [WORDS-1:0][23:0] mem;
	} frep_bank_s;

	frep_bank_s bank_ff;
	frep_bank_s nxt_bank;

	// Low word and high byte fill one latch independently
	always_comb
	begin
		nxt_bank = bank_ff;
		if (lat.wr_lo)
		begin
			nxt_bank.mem[lat.sel][15:0] = lat.wdata;
		end
		if (lat.wr_hi)
		begin
			nxt_bank.mem[lat.sel][23:16] = lat.wdata[7:0];
		end
	end

	// Latches hold stale data until rewritten; reset clears them
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			bank_ff <= '0;
		end
		else
		begin
			bank_ff <= nxt_bank;
		end
	end

	// Whole row is visible at once so a program cycle can take it in one edge
	assign lat.row = bank_ff.mem;

endmodule

// ### core/frep_flash_timer.sv
/*
 * Cycle timer for one erase or program cycle.
 * Assumes start is a one-cycle pulse while the timer is idle.
 */
`timescale 1ns/10ps
module frep_flash_timer
#(
	parameter int CNT_W = 24
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic start_i,
	input wire logic [CNT_W-1:0] len_i,
	output logic done_o
);

	typedef struct packed
	{
		logic [CNT_W-1:0] cnt;
		logic run;
		logic done;
	} frep_tmr_s;

	frep_tmr_s tmr_ff;
	frep_tmr_s nxt_tmr;

	// Count down the cycle length, pulse done at the end
	always_comb
	begin
		nxt_tmr = tmr_ff;
		nxt_tmr.done = 1'b0;
		if (start_i)
		begin
			nxt_tmr.run = 1'b1;
			nxt_tmr.cnt = len_i;
		end
		else if (tmr_ff.run)
		begin
			if (tmr_ff.cnt <= CNT_W'(1))
			begin
				nxt_tmr.run = 1'b0;
				nxt_tmr.done = 1'b1;
			end
			else
			begin
				nxt_tmr.cnt = tmr_ff.cnt - CNT_W'(1);
			end
		end
	end

	// Timer state register
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			tmr_ff <= '0;
		end
		else
		begin
			tmr_ff <= nxt_tmr;
		end
	end

	assign done_o = tmr_ff.done;

endmodule

// ### sim/frep_seq_asserts.sv
/*
 * Port checks for the flash row sequencer.
 * Assumes binding onto frep_seq with its cycle parameters.
 */
`timescale 1ns/10ps
module frep_seq_asserts
#(
	parameter int ERASE_CYC = 20,
	parameter int PROG_CYC = 20
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic pready_o,
	// Stall and flash
	input wire logic stall_o,
	input wire logic fl_erase_o,
	input wire logic fl_prog_o,
	input wire logic [23:0] fl_row_addr_o
);
	// Longest wait for the end of a cycle, with slack
	localparam int LIM = ERASE_CYC + PROG_CYC + 8;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	ready_time_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("answer late");
	op_stall_a: assert property (fl_erase_o || fl_prog_o |-> stall_o)
		else $error("op without stall");
	row_align_a: assert property (fl_erase_o || fl_prog_o |-> fl_row_addr_o[5:0] == 6'h00)
		else $error("row not aligned");
	op_cause_a: assert property (fl_erase_o || fl_prog_o |->
		$past(psel_i && penable_i && pwrite_i && paddr_i == 12'h000))
		else $error("op without control write");
	op_single_a: assert property (!(fl_erase_o && fl_prog_o))
		else $error("erase and program together");
	stall_hold_a: assert property ($rose(stall_o) |-> stall_o[*8])
		else $error("stall too short");
	stall_end_a: assert property ($rose(stall_o) |-> ##[1:LIM] !stall_o)
		else $error("stall never ends");
	stall_cause_a: assert property ($rose(stall_o) |-> fl_erase_o || fl_prog_o)
		else $error("stall without op");
	erase_once_a: assert property (fl_erase_o |=> !fl_erase_o)
		else $error("erase pulse too long");
endmodule

bind frep_seq frep_seq_asserts #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) chk_u
(
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.psel_i(psel_i),
	.penable_i(penable_i),
	.pwrite_i(pwrite_i),
	.paddr_i(paddr_i),
	.pready_o(pready_o),
	.stall_o(stall_o),
	.fl_erase_o(fl_erase_o),
	.fl_prog_o(fl_prog_o),
	.fl_row_addr_o(fl_row_addr_o)
);

// ### sim/frep_core_model.sv
/*
 * Processor core model issuing APB register and table writes.
 * Assumes one clock shared with the sequencer.
 */
`timescale 1ns/10ps
module frep_core_model
(
	// Clock and answers
	input wire logic clk_i,
	input wire logic pready_i,
	input wire logic stall_i,
	// APB request
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o
);
	// Bus idle at time zero
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0;
	end

	// One transfer; released lines show inverted data so stale values never match
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do @(posedge clk_i); while (pready_i !== 1'b1);
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask

	// Unlock then start, nothing in between
	task automatic go(input logic [15:0] ctl);
		xfer(1'b1, 12'h00c, 32'h55);
		xfer(1'b1, 12'h00c, 32'haa);
		xfer(1'b1, 12'h000, {16'h0, ctl});
		while (stall_i) @(posedge clk_i);
		repeat (2) @(posedge clk_i);
	endtask
endmodule

// ### sim/frep_seq_tb.sv
/*
 * Self-checking bench for the flash row sequencer.
 * Assumes the core model drives APB and cycles are shortened to 20.
 */
`timescale 1ns/10ps
module frep_seq_tb;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, stall_o, fl_erase_o, fl_prog_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic [23:0] fl_row_addr_o, w;
	logic [767:0] fl_row_data_o, row;
	logic [32:0] rd_q[$], e;
	logic [793:0] op_q[$], o;
	int err_total = 0;
	int total_checks = 0;
	int seed = 32'h5bd2;
	// Shortened flash cycle so a run stays small; stall lasts two cycles longer
	localparam int CYC = 20;
	int stall_cnt = 0;

	always #2.5 clk_i = ~clk_i;

	frep_seq #(.ERASE_CYC(CYC), .PROG_CYC(CYC)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.stall_o(stall_o), .fl_erase_o(fl_erase_o), .fl_prog_o(fl_prog_o),
		.fl_row_addr_o(fl_row_addr_o), .fl_row_data_o(fl_row_data_o));
	frep_core_model core_u (.clk_i(clk_i), .pready_i(pready_o), .stall_i(stall_o),
		.psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
		.pwdata_o(pwdata_i));

	task automatic chk(input logic [767:0] seen, input logic [767:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		rd_q.push_back(x);
		core_u.xfer(1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		core_u.xfer(1'b1, a, d);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Read answers against the oldest note; error flag set means data is not looked at
	always @(posedge clk_i)
		if (pready_o === 1'b1 && pwrite_i === 1'b0)
		begin
			e = rd_q.pop_front();
			chk(768'(pslverr_o), 768'(e[32]));
			if (!e[32])
				chk(768'(prdata_o), 768'(e[31:0]));
		end

	// Stall length of each cycle; the core must stay held for the whole flash cycle
	always @(posedge clk_i)
		if (stall_o === 1'b1)
			stall_cnt++;
		else if (stall_cnt != 0)
		begin
			chk(768'(stall_cnt), 768'(CYC + 2));
			stall_cnt = 0;
		end

	// Flash requests; one that nobody noted counts as a mismatch
	always @(posedge clk_i)
		if (fl_erase_o === 1'b1 || fl_prog_o === 1'b1)
		begin
			if (op_q.size() == 0)
				chk(768'h1, 768'h0);
			else
			begin
				o = op_q.pop_front();
				chk(768'({fl_prog_o, fl_erase_o, fl_row_addr_o}), 768'(o[793:768]));
				if (o[793])
					chk(fl_row_data_o, o[767:0]);
			end
		end

	// Watchdog sized well past the expected few hundred cycles
	initial
	begin
		#100000;
		err_total++;
		wrap_up();
	end

	initial
	begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(12'h000, 33'h0);
		rd(12'h020, {1'b1, 32'h0});
		// Row erase from directly written address
		wr(12'h000, 32'h4041);
		wr(12'h008, 32'h12);
		wr(12'h004, 32'habff);
		op_q.push_back({2'b01, 24'h12abc0, 768'h0});
		core_u.go(16'hc041);
		rd(12'h000, 33'h41);
		rd(12'h004, 33'habff);
		// Starts that must be refused
		wr(12'h000, 32'hc041);
		wr(12'h000, 32'h4041);
		core_u.go(16'h8041);
		wr(12'h000, 32'h4041);
		wr(12'h00c, 32'h55);
		wr(12'h004, 32'h0);
		wr(12'h00c, 32'haa);
		wr(12'h000, 32'hc041);
		// Load latches in order, then overwrite word 7 out of order
		wr(12'h010, 32'h05);
		wr(12'h01c, 32'h1040);
		for (int i = 0; i < 32; i++)
		begin
			w = 24'($random(seed));
			row[24*i +: 24] = w;
			wr(12'h014, {16'h0, w[15:0]});
			wr(12'h018, {24'h800000, w[23:16]});
		end
		w = 24'($random(seed));
		row[168 +: 24] = w;
		wr(12'h01c, 32'h104e);
		wr(12'h014, {16'h0, w[15:0]});
		wr(12'h018, {24'h0, w[23:16]});
		rd(12'h008, 33'h05);
		rd(12'h004, 33'h104e);
		wr(12'h000, 32'h4001);
		op_q.push_back({2'b10, 24'h051040, row});
		core_u.go(16'hc001);
		rd(12'h000, 33'h01);
		// Erase address captured by a dummy table write instead of direct writes
		wr(12'h010, 32'h3c);
		wr(12'h01c, 32'h2a5f);
		wr(12'h014, 32'h0);
		wr(12'h000, 32'h4041);
		op_q.push_back({2'b01, 24'h3c2a40, 768'h0});
		core_u.go(16'hc041);
		// Let the last answers be checked; a note never matched is a mismatch
		repeat (2) @(posedge clk_i);
		chk(768'(op_q.size()), 768'h0);
		chk(768'(rd_q.size()), 768'h0);
		wrap_up();
	end
endmodule
